// >>> sdc_cal.sv
// Calibration controller of a 24-bit sigma-delta converter, APB slave.
// Assumes the converter delivers raw samples of the channel and source
// it is told to use; one clock, synchronous reset.
// How it works
// R1: Start bit write launches multi-conversion calibration.
// R2: Mode 00 internal, 01 ext offset, 10 ext gain.
// R3: Single-ended channels get no correction factors.
// R4: Result fields frozen while calibration runs.
// R5: Software selects single scan before calibrating.
// R6: Software keeps amplifier offset voltage at zero.
// R7: External calibration targets exactly one channel; the sequencer calibrates every selected differential target in turn.
// R8: Internal mode corrects all targets, then interrupts.
// R9: External operation yields one value per start.
// R10: Each external operation ends with completion interrupt.
// R11: Offset correction makes offset input read zero.
// R12: Gain correction maps span to full scale.
// R13: External reference applied before setting start.
// R14: Software calibrates at first differential use.
// R15: Software recalibrates after reference/mode/gain changes.
// R16: Correction registers writable, restored values apply.
// R17: Self-diagnosis visible through ordinary results.
// R18: Stored corrections applied to every result; single-ended channel results pass uncorrected.
// R19: Start bit self-clears when calibration completes.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module sdc_cal #(
	parameter int SAMPLES = sdc_pkg::CAL_SAMPLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        RAW_VALID,
	input  wire logic [2:0]  RAW_CH,
	input  wire logic [23:0] RAW_DATA,
	output logic             IRQ,
	output logic             CAL_ACTIVE,
	output logic [2:0]       CAL_CH,
	output logic [1:0]       CAL_SRC
);
	localparam int NCH = sdc_pkg::NCH;
	localparam int SH  = $clog2(SAMPLES);
	localparam int AW  = 24 + SH;
	// Samples still in flight after a source change: steering flop plus converter
	localparam int SETTLE = 2;

	if (SAMPLES < 1 || (1 << SH) != SAMPLES || SAMPLES > 64)
		$error("sdc_cal: SAMPLES must be a power of two up to 64");

	typedef enum logic [2:0] {
		SDC_IDLE = 3'h0,
		SDC_PICK = 3'h1,
		SDC_OFS  = 3'h3,
		SDC_GAIN = 3'h2,
		SDC_DIV  = 3'h6,
		SDC_NEXT = 3'h7,
		SDC_DONE = 3'h5
	} sdc_state_t;

	sdc_state_t             state_r;
	logic                   busy_r;
	logic [1:0]             mode_r;
	logic [sdc_pkg::AMP_W-1:0] amp_r [NCH];
	logic [23:0]            ofs_r [NCH];
	logic [23:0]            gain_r [NCH];
	logic [23:0]            res_data_r;
	logic [2:0]             res_ch_r;
	logic                   res_stat_r;
	logic [sdc_pkg::IRQ_W-1:0] ist_r;
	logic [sdc_pkg::IRQ_W-1:0] imask_r;
	logic [2:0]             ch_r;
	logic [AW-1:0]          acc_r;
	logic [6:0]             cnt_r;
	logic [1:0]             settle_r;
	logic                   div_go_r;
	logic [45:0]            div_num_r;
	logic [23:0]            div_den_r;
	logic                   div_done;
	logic [23:0]            div_quo;
	logic                   cv_valid;
	logic [23:0]            cv_data;
	logic [2:0]             cv_ch;
	logic                   wr_en;
	logic                   rd_en;
	logic                   smp;
	logic [AW-1:0]          acc_nxt;
	logic [23:0]            avg;
	logic [24:0]            span;
	logic [sdc_pkg::IRQ_W-1:0] ev;
	logic                   ch_ok;
	logic                   raw_se;

	// Map a byte address to a channel register index, or NCH if none
	function automatic logic [2:0] chan_of(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		if (a >= base && d[1:0] == 2'h0 && d[7:2] < 6'(NCH))
			chan_of = d[4:2];
		else
			chan_of = 3'(NCH);
	endfunction : chan_of

	// Differential target channel selected for calibration
	function automatic logic is_target(input logic [sdc_pkg::AMP_W-1:0] a);
		is_target = a[sdc_pkg::F_TGT] && !a[sdc_pkg::F_SE];
	endfunction : is_target

	assign wr_en  = PSEL && PENABLE && PREADY && PWRITE;
	assign rd_en  = PSEL && !PENABLE && !PWRITE;
	assign smp    = RAW_VALID && RAW_CH == ch_r && settle_r == 2'h0
		&& (state_r == SDC_OFS || state_r == SDC_GAIN);
	assign acc_nxt = acc_r + {{SH{RAW_DATA[23]}}, RAW_DATA};
	assign avg    = acc_nxt[AW-1:SH];
	assign span   = {avg[23], avg} + {ofs_r[ch_r][23], ofs_r[ch_r]};
	assign ch_ok  = (32'(ch_r) < NCH) && is_target(amp_r[ch_r]);
	assign raw_se = (32'(RAW_CH) < NCH) ? amp_r[RAW_CH][sdc_pkg::F_SE] : 1'b1;

	// APB access phase answer: zero wait states, registered
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
			if (PSEL && !PENABLE) begin
				if (PADDR == sdc_pkg::A_START)
					PRDATA <= {31'h0, busy_r};
				else if (PADDR == sdc_pkg::A_CTRL)
					PRDATA <= {30'h0, mode_r};
				else if (chan_of(PADDR, sdc_pkg::A_AMP0) != 3'(NCH))
					PRDATA <= 32'(amp_r[chan_of(PADDR, sdc_pkg::A_AMP0)]);
				else if (PADDR == sdc_pkg::A_RESULT)
					PRDATA <= {4'h0, res_stat_r, res_ch_r, res_data_r};
				else if (PADDR == sdc_pkg::A_ISTAT)
					PRDATA <= 32'(ist_r);
				else if (PADDR == sdc_pkg::A_IMASK)
					PRDATA <= 32'(imask_r);
				else if (chan_of(PADDR, sdc_pkg::A_OFS0) != 3'(NCH))
					PRDATA <= {8'h00, ofs_r[chan_of(PADDR, sdc_pkg::A_OFS0)]};
				else if (chan_of(PADDR, sdc_pkg::A_GAIN0) != 3'(NCH))
					PRDATA <= {8'h00, gain_r[chan_of(PADDR, sdc_pkg::A_GAIN0)]};
				else
					PSLVERR <= 1'b1;
			end
		end
	end

	// Mode and per-channel amplifier control
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			mode_r <= sdc_pkg::M_INT;
			for (int i = 0; i < NCH; i++)
				amp_r[i] <= '0;
		end else if (wr_en && !busy_r) begin
			if (PADDR == sdc_pkg::A_CTRL)
				mode_r <= PWDATA[1:0];
			for (int i = 0; i < NCH; i++)
				if (chan_of(PADDR, sdc_pkg::A_AMP0) == 3'(i))
					amp_r[i] <= PWDATA[sdc_pkg::AMP_W-1:0];
		end
	end

	// Correction values: software restore or calibration result
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < NCH; i++) begin
				ofs_r[i]  <= sdc_pkg::OFS_RESET;
				gain_r[i] <= sdc_pkg::GAIN_UNITY;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_en && !busy_r && chan_of(PADDR, sdc_pkg::A_OFS0) == 3'(i))
					ofs_r[i] <= PWDATA[23:0]; // [R16]
				if (wr_en && !busy_r && chan_of(PADDR, sdc_pkg::A_GAIN0) == 3'(i))
					gain_r[i] <= PWDATA[23:0]; // [R16]
			end
			if (state_r == SDC_OFS && smp && cnt_r == 7'(SAMPLES - 1))
				ofs_r[ch_r] <= 24'h000000 - avg; // [R11]
			if (state_r == SDC_DIV && div_done)
				gain_r[ch_r] <= div_quo; // [R12]
		end
	end

	// Calibration sequencer
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_r   <= SDC_IDLE;
			busy_r    <= 1'b0;
			ch_r      <= 3'h0;
			acc_r     <= '0;
			cnt_r     <= 7'h00;
			div_go_r  <= 1'b0;
			div_num_r <= '0;
			div_den_r <= 24'h000000;
			settle_r  <= 2'h0;
		end else begin
			div_go_r <= 1'b0;
			// Drop stale samples of the old source after each phase entry
			if (settle_r != 2'h0)
				settle_r <= settle_r - 2'h1;
			case (state_r)
				SDC_IDLE: begin
					if (wr_en && PADDR == sdc_pkg::A_START && PWDATA[0]) begin
						busy_r  <= 1'b1; // [R1]
						ch_r    <= 3'h0;
						state_r <= SDC_PICK;
					end
				end
				SDC_PICK: begin
					settle_r <= 2'(SETTLE);
					acc_r <= '0;
					cnt_r <= 7'h00;
					if (32'(ch_r) >= NCH || mode_r == 2'h3)
						state_r <= SDC_DONE;
					else if (!ch_ok)
						ch_r <= ch_r + 3'h1; // [R2] [R3]
					else if (mode_r == sdc_pkg::M_EXT_GAIN)
						state_r <= SDC_GAIN; // [R2]
					else
						state_r <= SDC_OFS; // [R2]
				end
				SDC_OFS: begin
					if (smp) begin
						acc_r <= acc_nxt;
						cnt_r <= cnt_r + 7'h01;
						if (cnt_r == 7'(SAMPLES - 1)) begin
							acc_r   <= '0;
							cnt_r   <= 7'h00;
							settle_r <= 2'(SETTLE);
							// Internal runs on to gain; external stops here
							state_r <= (mode_r == sdc_pkg::M_INT) ? SDC_GAIN : SDC_NEXT; // [R8] [R9]
						end
					end
				end
				SDC_GAIN: begin
					if (smp) begin
						acc_r <= acc_nxt;
						cnt_r <= cnt_r + 7'h01;
						if (cnt_r == 7'(SAMPLES - 1)) begin
							div_go_r  <= 1'b1;
							// Target code times unity, over measured span
							div_num_r <= (mode_r == sdc_pkg::M_INT)
								? {sdc_pkg::INT_REF_CODE, 22'h0}
								: {sdc_pkg::FULL_SCALE, 22'h0}; // [R12]
							div_den_r <= (span[24] || span[23:0] == 24'h0) ? 24'h000001 : span[23:0];
							state_r   <= SDC_DIV;
						end
					end
				end
				SDC_DIV: begin
					if (div_done)
						state_r <= SDC_NEXT;
				end
				SDC_NEXT: begin
					ch_r    <= ch_r + 3'h1; // [R8]
					state_r <= SDC_PICK;
				end
				SDC_DONE: begin
					busy_r  <= 1'b0; // [R19]
					state_r <= SDC_IDLE;
				end
				default: begin
					busy_r  <= 1'b0;
					state_r <= SDC_IDLE;
				end
			endcase
		end
	end

	// Converter steering during calibration
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			CAL_ACTIVE <= 1'b0;
			CAL_CH     <= 3'h0;
			CAL_SRC    <= sdc_pkg::S_NORMAL;
		end else begin
			CAL_ACTIVE <= busy_r;
			CAL_CH     <= ch_r;
			if (state_r == SDC_OFS)
				CAL_SRC <= (mode_r == sdc_pkg::M_INT) ? sdc_pkg::S_INT_ZERO : sdc_pkg::S_EXT;
			else if (state_r == SDC_GAIN)
				CAL_SRC <= (mode_r == sdc_pkg::M_INT) ? sdc_pkg::S_INT_REF : sdc_pkg::S_EXT;
			else
				CAL_SRC <= sdc_pkg::S_NORMAL;
		end
	end

	// Result register, frozen while calibrating
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			res_data_r <= 24'h000000;
			res_ch_r   <= 3'h0;
			res_stat_r <= 1'b0;
		end else if (cv_valid && !busy_r) begin // [R4]
			res_data_r <= cv_data; // [R17]
			res_ch_r   <= cv_ch;
			res_stat_r <= 1'b1;
		end else if (rd_en && PADDR == sdc_pkg::A_RESULT && !busy_r)
			res_stat_r <= 1'b0;
	end

	// Sticky interrupt status, write one to clear, set wins
	assign ev = {cv_valid && !busy_r, state_r == SDC_DONE}; // [R8] [R10]
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ist_r   <= '0;
			imask_r <= '0;
			IRQ     <= 1'b0;
		end else begin
			if (wr_en && PADDR == sdc_pkg::A_IMASK)
				imask_r <= PWDATA[sdc_pkg::IRQ_W-1:0];
			if (wr_en && PADDR == sdc_pkg::A_ISTAT)
				ist_r <= (ist_r & ~PWDATA[sdc_pkg::IRQ_W-1:0]) | ev;
			else
				ist_r <= ist_r | ev;
			IRQ <= |(ist_r & imask_r);
		end
	end

	// Per-result correction with the channel's stored factors
	sdc_corr u_corr (
		.clk       (CORE_CLK),
		.rst       (SYS_RST),
		.in_valid  (RAW_VALID && !busy_r),
		.in_data   (RAW_DATA),
		.in_ch     (RAW_CH),
		.bypass    (raw_se),
		.ofs       (ofs_r[(32'(RAW_CH) < NCH) ? RAW_CH : 3'h0]),
		.gain      (gain_r[(32'(RAW_CH) < NCH) ? RAW_CH : 3'h0]),
		.out_valid (cv_valid),
		.out_data  (cv_data),
		.out_ch    (cv_ch)
	); // [R18]

	// Gain factor division
	sdc_div #(
		.NW (46),
		.QW (24)
	) u_div (
		.clk   (CORE_CLK),
		.rst   (SYS_RST),
		.start (div_go_r),
		.num   (div_num_r),
		.den   (div_den_r),
		.done  (div_done),
		.quo   (div_quo)
	);
endmodule : sdc_cal

// >>> sdc_cal_bench.sv
// Testbench of the calibration controller: APB tasks and calibration runs.
// Assumes the converter is stood in for here, sampling the source on CAL_SRC.
`timescale 1ns/1ps
module sdc_cal_bench;
	logic        CORE_CLK  = 1'h0;
	logic        SYS_RST   = 1'h1;
	logic        PSEL      = 1'h0;
	logic        PENABLE   = 1'h0;
	logic        PWRITE    = 1'h0;
	logic [7:0]  PADDR     = 8'h00;
	logic [31:0] PWDATA    = 32'h0;
	logic        RAW_VALID = 1'h0;
	logic [2:0]  RAW_CH    = 3'h0;
	logic [23:0] RAW_DATA  = 24'h0;
	logic [31:0] PRDATA;
	logic        PREADY, PSLVERR, IRQ, CAL_ACTIVE, err;
	logic [2:0]  CAL_CH;
	logic [1:0]  CAL_SRC;
	logic        man_v     = 1'h0;
	logic [2:0]  man_ch    = 3'h0;
	logic [23:0] man_d     = 24'h0;
	logic [23:0] ext_v     = 24'h0;
	logic [31:0] rd;
	logic [31:0] ea [5]    = '{32'h2, 32'h1, 32'h0, 32'h2, 32'h3};
	logic [31:0] eo [5]    = '{32'hFFFFE0, 32'h0, 32'hFFFF00, 32'hFFFFE0, 32'h0};
	logic [31:0] eg [5]    = '{32'h800000, 32'h400000, 32'hFFFFFE, 32'h800000, 32'h400000};
	int          bad_count = 0;
	int          cmp_count = 0;

	sdc_cal #(.SAMPLES(4)) dut (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.RAW_VALID(RAW_VALID), .RAW_CH(RAW_CH), .RAW_DATA(RAW_DATA), .IRQ(IRQ),
		.CAL_ACTIVE(CAL_ACTIVE), .CAL_CH(CAL_CH), .CAL_SRC(CAL_SRC)
	);

	// 10 MHz clock
	always #50 CORE_CLK = ~CORE_CLK;

	// Converter stand-in: internal zero reads 0x20, internal ref 0x200020
	always @(posedge CORE_CLK) begin
		RAW_VALID <= (CAL_ACTIVE && CAL_SRC != sdc_pkg::S_NORMAL) || man_v;
		RAW_CH    <= CAL_ACTIVE ? CAL_CH : man_ch;
		case (CAL_SRC)
			sdc_pkg::S_INT_ZERO: RAW_DATA <= 24'h000020;
			sdc_pkg::S_INT_REF:  RAW_DATA <= 24'h200020;
			sdc_pkg::S_EXT:      RAW_DATA <= ext_v;
			default:             RAW_DATA <= man_d;
		endcase
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, held until ready, then one idle cycle
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		do @(posedge CORE_CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CORE_CLK);
	endtask : rw

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rw(1'h1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rw(1'h0, a, 32'h0);
		chk(rd, e);
	endtask : rc

	task automatic irq_is(input logic e);
		@(posedge CORE_CLK);
		chk({31'h0, IRQ}, {31'h0, e});
	endtask : irq_is

	// Normal conversion sample from the converter
	task automatic sample(input logic [2:0] c, input logic [23:0] d);
		man_v <= 1'h1;
		man_ch <= c;
		man_d <= d;
		@(posedge CORE_CLK);
		man_v <= 1'h0;
		repeat (4) @(posedge CORE_CLK);
	endtask : sample

	// Runs one calibration and waits for its completion interrupt
	task automatic cal(input logic [1:0] m, input logic [23:0] v);
		ext_v = v;
		wr(sdc_pkg::A_CTRL, {30'h0, m});
		wr(sdc_pkg::A_START, 32'h1);
		rc(sdc_pkg::A_START, 32'h1);
		for (int i = 0; i < 4000 && IRQ !== 1'h1; i++)
			@(posedge CORE_CLK);
		chk({31'h0, IRQ}, 32'h1);
		rc(sdc_pkg::A_START, 32'h0);
		rw(1'h0, sdc_pkg::A_ISTAT, 32'h0);
		chk(rd & 32'h1, 32'h1);
	endtask : cal

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Watchdog: the tests need well under a thousand cycles, allow 30000
	initial begin
		#3000000;
		bad_count++;
		results();
	end

	// Test sequence
	initial begin
		repeat (16) @(posedge CORE_CLK);
		SYS_RST <= 1'h0;
		rc(sdc_pkg::A_GAIN0, 32'h400000);
		rc(sdc_pkg::A_OFS0, 32'h0);
		rw(1'h0, 8'h80, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset done");
		wr(sdc_pkg::A_OFS0, 32'hFFFFF0);
		wr(sdc_pkg::A_GAIN0, 32'h800000);
		wr(sdc_pkg::A_AMP0 + 8'h4, 32'h1);
		sample(3'h0, 24'h000100);
		rc(sdc_pkg::A_RESULT, 32'h080001E0);
		sample(3'h1, 24'h000100);
		rc(sdc_pkg::A_RESULT, 32'h09000100);
		sample(3'h2, 24'h000200);
		rc(sdc_pkg::A_ISTAT, 32'h2);
		wr(sdc_pkg::A_ISTAT, 32'h2);
		$display("test correction done");
		wr(sdc_pkg::A_IMASK, 32'h1);
		wr(sdc_pkg::A_AMP0 + 8'h8, 32'h2);
		cal(2'h1, 24'h000100);
		rc(sdc_pkg::A_OFS0 + 8'h8, 32'hFFFF00);
		rc(sdc_pkg::A_GAIN0 + 8'h8, 32'h400000);
		rc(sdc_pkg::A_RESULT, 32'h0A000200);
		wr(sdc_pkg::A_IMASK, 32'h0);
		irq_is(1'h0);
		wr(sdc_pkg::A_IMASK, 32'h1);
		irq_is(1'h1);
		wr(sdc_pkg::A_ISTAT, 32'h1);
		irq_is(1'h0);
		$display("test external offset done");
		cal(2'h2, 24'h200100);
		rc(sdc_pkg::A_GAIN0 + 8'h8, 32'hFFFFFE);
		rc(sdc_pkg::A_OFS0 + 8'h8, 32'hFFFF00);
		wr(sdc_pkg::A_ISTAT, 32'h1);
		sample(3'h2, 24'h200100);
		rc(sdc_pkg::A_RESULT, 32'h0A7FFFFF);
		$display("test external gain done");
		for (int i = 0; i < 5; i++)
			wr(sdc_pkg::A_AMP0 + 8'(4 * i), ea[i]);
		cal(2'h0, 24'h0);
		for (int i = 0; i < 5; i++) begin
			rc(sdc_pkg::A_OFS0 + 8'(4 * i), eo[i]);
			rc(sdc_pkg::A_GAIN0 + 8'(4 * i), eg[i]);
		end
		// Reserved mode ends at once with the done event, factors untouched
		wr(sdc_pkg::A_ISTAT, 32'h1);
		cal(2'h3, 24'h0);
		rc(sdc_pkg::A_GAIN0, 32'h800000);
		$display("test internal done");
		results();
	end
endmodule : sdc_cal_bench

// >>> sdc_cal_chk.sv
// Checker of the calibration controller: bus answers and start behaviour.
// Assumes it is bound to sdc_cal and sees only that module's ports.
`timescale 1ns/1ps
module sdc_cal_chk (
	input wire logic        CORE_CLK,
	input wire logic        SYS_RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        CAL_ACTIVE,
	input wire logic [1:0]  CAL_SRC
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	// Zero-wait bus: ready in the first access cycle, for one cycle
	a_ready_first: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing in access cycle");
	a_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
		else $error("ready without a setup cycle");
	a_ready_once: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	// Aligned addresses: error response only past the last correction word
	a_err_map: assert property (PREADY && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > 8'h4C))
		else $error("error response on wrong address");
	a_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h00000000)
		else $error("error response carries data");
	// Start write launches a calibration
	a_start_go: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[0]
		&& !CAL_ACTIVE |-> ##[1:3] CAL_ACTIVE)
		else $error("start write did not launch calibration");
	// Calibration sources only requested while busy
	a_src_busy: assert property (CAL_SRC != sdc_pkg::S_NORMAL |-> ##[0:1] CAL_ACTIVE)
		else $error("calibration source while idle");
	a_src_idle: assert property (!CAL_ACTIVE [*3] |-> CAL_SRC == sdc_pkg::S_NORMAL)
		else $error("idle converter not on normal input");
	// Main scenarios reached
	c_err: cover property (PSLVERR);
	c_cal: cover property ($rose(CAL_ACTIVE));
	c_ext: cover property (CAL_SRC == sdc_pkg::S_EXT);
endmodule : sdc_cal_chk

bind sdc_cal sdc_cal_chk u_chk (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.CAL_ACTIVE(CAL_ACTIVE), .CAL_SRC(CAL_SRC)
);

// >>> sdc_corr.sv
// Applies offset and gain correction to one raw conversion sample.
// Assumes gain is unsigned with unity at 2^22; output is registered.
`timescale 1ns/1ps
module sdc_corr (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        in_valid,
	input  wire logic [23:0] in_data,
	input  wire logic [2:0]  in_ch,
	input  wire logic        bypass,
	input  wire logic [23:0] ofs,
	input  wire logic [23:0] gain,
	output logic             out_valid,
	output logic [23:0]      out_data,
	output logic [2:0]       out_ch
);
	logic signed [24:0] sum;
	logic signed [49:0] prod;
	logic signed [27:0] scaled;

	// Add offset, scale, saturate to 24 bits
	assign sum    = $signed({in_data[23], in_data}) + $signed({ofs[23], ofs});
	assign prod   = sum * $signed({1'b0, gain});
	assign scaled = prod[sdc_pkg::GFRAC+27:sdc_pkg::GFRAC];
	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data  <= 24'h000000;
			out_ch    <= 3'h0;
		end else begin
			out_valid <= in_valid;
			out_ch    <= in_ch;
			if (bypass)
				out_data <= in_data;
			else if (scaled > 28'sh07FFFFF)
				out_data <= 24'h7FFFFF;
			else if (scaled < -28'sh0800000)
				out_data <= 24'h800000;
			else
				out_data <= scaled[23:0];
		end
	end
endmodule : sdc_corr

// >>> sdc_div.sv
// Restoring unsigned divider for the gain correction factor.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps
module sdc_div #(
	parameter int NW = 46,
	parameter int QW = 24
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic [NW-1:0] num,
	input  wire logic [QW-1:0] den,
	output logic               done,
	output logic [QW-1:0]      quo
);
	logic [NW-1:0] q_r;
	logic [NW-1:0] q_nxt;
	logic [QW:0]   rem_r;
	logic [6:0]    cnt_r;
	logic          run_r;
	logic [QW+1:0] trial;

	// Widths that the step counter and the clipping can serve
	if (NW > 127 || NW <= QW || QW < 2)
		$error("sdc_div: bad widths");

	// One quotient bit per cycle
	assign trial = {rem_r, q_r[NW-1]} - {2'h0, den};
	assign q_nxt = {q_r[NW-2:0], !trial[QW+1]};
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 1'b0;
			cnt_r <= 7'h00;
			q_r   <= '0;
			rem_r <= '0;
			done  <= 1'b0;
			quo   <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				run_r <= 1'b1;
				cnt_r <= 7'(NW);
				q_r   <= num;
				rem_r <= '0;
			end else if (run_r) begin
				q_r   <= q_nxt;
				rem_r <= trial[QW+1] ? {rem_r[QW-1:0], q_r[NW-1]} : trial[QW:0];
				cnt_r <= cnt_r - 7'h01;
				if (cnt_r == 7'h01) begin
					run_r <= 1'b0;
					done  <= 1'b1;
					// Result stands with done; quotients past QW bits clip to all ones
					quo   <= (|q_nxt[NW-1:QW]) ? {QW{1'b1}} : q_nxt[QW-1:0];
				end
			end
		end
	end
endmodule : sdc_div

// >>> sdc_pkg.sv
// Shared constants of the sigma-delta calibration controller.
// Assumes a 32-bit APB slave port with byte addresses.
package sdc_pkg;
	localparam int          NCH          = 5;
	localparam int          DW           = 24;
	// Register byte offsets
	localparam logic [7:0]  A_START      = 8'h00;
	localparam logic [7:0]  A_CTRL       = 8'h04;
	localparam logic [7:0]  A_AMP0       = 8'h08;
	localparam logic [7:0]  A_RESULT     = 8'h1C;
	localparam logic [7:0]  A_ISTAT      = 8'h20;
	localparam logic [7:0]  A_IMASK      = 8'h24;
	localparam logic [7:0]  A_OFS0       = 8'h28;
	localparam logic [7:0]  A_GAIN0      = 8'h3C;
	// Amplifier control fields
	localparam int          F_SE         = 0;
	localparam int          F_TGT        = 1;
	localparam int          F_OFSV_LO    = 2;
	localparam int          F_GAIN_LO    = 7;
	localparam int          AMP_W        = 12;
	// Result fields
	localparam int          F_RCH_LO     = 24;
	localparam int          F_RSTAT      = 27;
	// Interrupt bits
	localparam int          I_CALDONE    = 0;
	localparam int          I_RESULT     = 1;
	localparam int          IRQ_W        = 2;
	// Calibration modes
	localparam logic [1:0]  M_INT        = 2'h0;
	localparam logic [1:0]  M_EXT_OFS    = 2'h1;
	localparam logic [1:0]  M_EXT_GAIN   = 2'h2;
	// Converter input sources
	localparam logic [1:0]  S_NORMAL     = 2'h0;
	localparam logic [1:0]  S_INT_ZERO   = 2'h1;
	localparam logic [1:0]  S_INT_REF    = 2'h2;
	localparam logic [1:0]  S_EXT        = 2'h3;
	// Gain format: unity is 2^22
	localparam int          GFRAC        = 22;
	localparam logic [23:0] GAIN_UNITY   = 24'h400000;
	localparam logic [23:0] OFS_RESET    = 24'h000000;
	localparam logic [23:0] FULL_SCALE   = 24'h7FFFFF;
	localparam logic [23:0] INT_REF_CODE = 24'h400000;
	localparam int          CAL_SAMPLES  = 4;
endpackage : sdc_pkg
